// >>> rom_config_loader.sv
// configuration loader top: reset sequencing, byte image, retry and register port
`timescale 1ns/1ps
// Operation
// - load starts only if strap reads low at first pci reset release after global reset
// - every pci slave access during the load is answered with retry
// - each fetched byte lands in the field its rom address maps to
// - fields span link config, link controller, bridge and card function spaces
// - rom bytes 34h..37h form unique id low word, lowest byte in bits 7:0
// - byte 20h loads self id write enable, pm top bit enable, irq pin select
// - byte 22h loads led routing to both led outputs and pulse length select
// - bytes 34h,35h,36h,37h fill id low bits 7:0,15:8,23:16,31:24 in order
// - rom link runs at 100 khz with 7-bit device addressing
// - strap high at sampling skips the load, registers keep defaults
// - an enabled load turns user io pins three and four into clock and data
module rom_config_loader
  import rom_loader_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_link_clk,
  input wire logic i_pci_reset_n,
  input wire logic i_speaker_strap_pin,
  input wire logic i_slave_access,
  input wire logic i_user_io_pin_four_in,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_slave_retry,
  output logic o_load_busy,
  output logic o_rom_pins_active,
  output logic o_user_io_pin_three_out,
  output logic o_user_io_pin_three_oe,
  output logic o_user_io_pin_four_out,
  output logic o_user_io_pin_four_oe,
  output logic [15:0] o_subsys_vendor_id,
  output logic [15:0] o_subsys_id,
  output logic o_self_ident_write_enable,
  output logic o_pm_top_bit_write_enable,
  output logic [1:0] o_irq_pin_select,
  output logic o_link_activity_to_led_one,
  output logic o_link_activity_to_led_zero,
  output logic [1:0] o_led_pulse_length_select,
  output logic [31:0] o_config_rom_header,
  output logic [31:0] o_bus_options,
  output logic [31:0] o_guid_high,
  output logic [31:0] o_guid_low
);
  logic [7:0] img_q [IMG_BYTES];
  logic pci_rst_s;
  logic strap_s;
  logic pci_rst_prev_q;
  logic sampled_q;
  logic loading_q;
  logic done_q;
  logic skipped_q;
  logic start_tg_q;
  logic start_link_s;
  logic [5:0] wr_addr_q;
  logic byte_prev_q;
  logic done_prev_q;
  logic [2:0] ret_s;
  logic [7:0] rom_byte;
  logic rom_byte_tg;
  logic rom_done_tg;
  logic rom_nack;
  logic scl_oe;
  logic sda_oe;

  sync2 #(.W(2)) u_pin_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_d({i_pci_reset_n, i_speaker_strap_pin}),
    .o_q({pci_rst_s, strap_s})
  );

  sync2 #(.W(1)) u_start_sync (
    .i_clk(i_link_clk),
    .i_reset_n(i_reset_n),
    .i_d(start_tg_q),
    .o_q(start_link_s)
  );

  // byte data stays stable for a whole rom byte time, so only the toggles and the nack level cross
  sync2 #(.W(3)) u_ret_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_d({rom_byte_tg, rom_done_tg, rom_nack}),
    .o_q(ret_s)
  );

  rom_reader u_reader (
    .i_link_clk(i_link_clk),
    .i_reset_n(i_reset_n),
    .i_start_lvl(start_link_s),
    .i_sda_in(i_user_io_pin_four_in),
    .o_scl_oe(scl_oe),
    .o_sda_oe(sda_oe),
    .o_byte(rom_byte),
    .o_byte_tg(rom_byte_tg),
    .o_done_tg(rom_done_tg),
    .o_nack(rom_nack)
  );

  wire pci_release = pci_rst_s && !pci_rst_prev_q && !sampled_q;
  wire first_start = pci_release && !strap_s;
  wire ctrl_hit = i_wr && (i_addr == REG_CTRL);
  wire reload = ctrl_hit && i_wdata[CTRL_RELOAD_BIT] && !loading_q && o_rom_pins_active;
  wire start_load = first_start || reload;
  // one busy view for status, retry and the busy pin
  wire busy_c = loading_q || start_load;
  wire byte_ev = (ret_s[2] ^ byte_prev_q) && loading_q;
  wire done_ev = (ret_s[1] ^ done_prev_q) && loading_q;
  wire img_sel = (i_addr < 8'(IMG_BYTES));
  wire [7:0] status_word = {4'h0, ret_s[0], skipped_q, done_q, busy_c};
  wire [7:0] rd_word = img_sel ? img_q[i_addr[5:0]] :
                       (i_addr == REG_STATUS) ? status_word : 8'h00;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pci_rst_prev_q <= 1'b0;
      sampled_q <= 1'b0;
      loading_q <= 1'b0;
      done_q <= 1'b0;
      skipped_q <= 1'b0;
      start_tg_q <= 1'b0;
      o_rom_pins_active <= 1'b0;
    end else begin
      pci_rst_prev_q <= pci_rst_s;
      if (pci_release) sampled_q <= 1'b1;
      if (pci_release && strap_s) skipped_q <= 1'b1;
      if (first_start) o_rom_pins_active <= 1'b1;
      if (start_load) begin
        start_tg_q <= ~start_tg_q;
        loading_q <= 1'b1;
        done_q <= 1'b0;
      end else if (done_ev) begin
        loading_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_addr_q <= '0;
      byte_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      byte_prev_q <= ret_s[2];
      done_prev_q <= ret_s[1];
      if (start_load) wr_addr_q <= '0;
      else if (byte_ev) wr_addr_q <= wr_addr_q + 6'd1;
    end
  end

  // one entry per mapped rom byte; reserved bits keep their default
  for (genvar g = 0; g < IMG_BYTES; g++) begin : g_img
    localparam logic [5:0] A = 6'(g);
    localparam logic [7:0] M = rom_byte_mask(A);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) img_q[g] <= IMG_DEFAULT;
      else if (byte_ev && wr_addr_q == A) img_q[g] <= (rom_byte & M) | (img_q[g] & ~M);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
      o_slave_retry <= 1'b0;
      o_load_busy <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_word : 8'h00;
      o_slave_retry <= i_slave_access && busy_c;
      o_load_busy <= busy_c;
    end
  end

  // open-drain pins driven low only; retimed on the link clock
  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_user_io_pin_three_oe <= 1'b0;
      o_user_io_pin_four_oe <= 1'b0;
    end else begin
      o_user_io_pin_three_oe <= scl_oe;
      o_user_io_pin_four_oe <= sda_oe;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_user_io_pin_three_out <= 1'b0;
      o_user_io_pin_four_out <= 1'b0;
    end else begin
      o_user_io_pin_three_out <= 1'b0;
      o_user_io_pin_four_out <= 1'b0;
    end
  end

  // field views of the image, covers the link spaces held here
  assign o_subsys_vendor_id = {img_q[BYTE_SSVID + 6'd1], img_q[BYTE_SSVID]};
  assign o_subsys_id = {img_q[BYTE_SSID_HI], img_q[BYTE_SSID]};
  assign o_self_ident_write_enable = img_q[BYTE_WREN][SELF_ID_WREN_BIT];
  assign o_pm_top_bit_write_enable = img_q[BYTE_WREN][PM_TOP_WREN_BIT];
  assign o_irq_pin_select = img_q[BYTE_WREN][1:0];
  assign o_link_activity_to_led_one = img_q[BYTE_LED][LED_ONE_BIT];
  assign o_link_activity_to_led_zero = img_q[BYTE_LED][LED_ZERO_BIT];
  assign o_led_pulse_length_select = img_q[BYTE_LED][LED_DUR_LSB +: 2];
  assign o_config_rom_header = {img_q[BYTE_ROMHDR + 6'd3], img_q[BYTE_ROMHDR + 6'd2],
                                img_q[BYTE_ROMHDR + 6'd1], img_q[BYTE_ROMHDR]};
  assign o_bus_options = {img_q[BYTE_BUSOPT + 6'd3], img_q[BYTE_BUSOPT + 6'd2],
                          img_q[BYTE_BUSOPT + 6'd1], img_q[BYTE_BUSOPT]};
  assign o_guid_high = {img_q[BYTE_GUID_HI + 6'd3], img_q[BYTE_GUID_HI + 6'd2],
                        img_q[BYTE_GUID_HI + 6'd1], img_q[BYTE_GUID_HI]};
  assign o_guid_low = {img_q[BYTE_GUID_LO + 6'd3], img_q[BYTE_GUID_LO + 6'd2],
                       img_q[BYTE_GUID_LO + 6'd1], img_q[BYTE_GUID_LO]};
endmodule

// >>> rom_loader_checker.sv
// port assertions for the rom configuration loader
`timescale 1ns/1ps
module rom_loader_checker
  import rom_loader_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_link_clk,
  input wire logic i_reset_n,
  input wire logic i_slave_access,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_slave_retry,
  input wire logic o_load_busy,
  input wire logic o_rom_pins_active,
  input wire logic o_user_io_pin_three_oe,
  input wire logic o_user_io_pin_four_oe,
  input wire logic [1:0] o_irq_pin_select,
  input wire logic [1:0] o_led_pulse_length_select,
  input wire logic [31:0] o_guid_low
);
  wire [7:0] id_b0 = o_guid_low[7:0];
  wire [7:0] id_b2 = o_guid_low[23:16];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  retry_during_load_a: assert property (i_slave_access |=> o_slave_retry == o_load_busy)
    else $error("access not retried during load");
  retry_needs_access_a: assert property (!i_slave_access |=> !o_slave_retry)
    else $error("retry without access");
  rdata_quiet_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read slot");
  status_busy_a: assert property (i_rd && i_addr == REG_STATUS
    |=> o_rdata[0] == o_load_busy)
    else $error("status busy bit wrong");
  id_low_byte_a: assert property (i_rd && i_addr == 8'h34 |=> o_rdata == $past(id_b0))
    else $error("id low byte mismatch");
  id_third_byte_a: assert property (i_rd && i_addr == 8'h36 |=> o_rdata == $past(id_b2))
    else $error("id third byte mismatch");
  irq_select_a: assert property (i_rd && i_addr == 8'h20
    |=> o_rdata[1:0] == $past(o_irq_pin_select))
    else $error("irq select field mismatch");
  led_length_a: assert property (i_rd && i_addr == 8'h22
    |=> o_rdata[4:3] == $past(o_led_pulse_length_select))
    else $error("led length field mismatch");
  image_hold_a: assert property (!o_load_busy ##1 !o_load_busy |-> $stable(o_guid_low))
    else $error("field changed while idle");
  busy_pins_a: assert property (o_load_busy |-> ##[0:2] o_rom_pins_active)
    else $error("load without rom pins");
  pins_released_a: assert property (@(posedge i_link_clk) disable iff (!i_reset_n)
    !o_rom_pins_active |-> !o_user_io_pin_three_oe && !o_user_io_pin_four_oe)
    else $error("pins driven while not assigned");
  busy_start_c: cover property ($rose(o_load_busy));
  retry_seen_c: cover property (o_slave_retry);
  load_end_c: cover property ($fell(o_load_busy));
endmodule
bind rom_config_loader rom_loader_checker u_rom_loader_checker (.i_clk, .i_link_clk, .i_reset_n,
  .i_slave_access, .i_addr, .i_rd, .o_rdata, .o_slave_retry, .o_load_busy, .o_rom_pins_active,
  .o_user_io_pin_three_oe, .o_user_io_pin_four_oe, .o_irq_pin_select,
  .o_led_pulse_length_select, .o_guid_low);

// >>> rom_loader_pkg.sv
// shared constants for the serial rom configuration loader
package rom_loader_pkg;
  // link timing: 100 kHz standard mode, link clock period 6 ns
  localparam int SCL_PERIOD_NS = 10000;
  localparam int LINK_CLK_PERIOD_PS = 6000;
  localparam int QUARTER_CYC = (SCL_PERIOD_NS * 1000) / (4 * LINK_CLK_PERIOD_PS);
  localparam logic [9:0] QUARTER_LAST = 10'(QUARTER_CYC - 1);
  // 7-bit rom device address, plain default
  localparam logic [6:0] ROM_DEV_ADDR = 7'h50;
  localparam logic [7:0] ROM_WORD_ADDR = 8'h00;
  // mapped image spans bytes 00h..37h
  localparam int IMG_BYTES = 56;
  localparam logic [5:0] IMG_LAST = 6'h37;
  localparam logic [7:0] IMG_DEFAULT = 8'h00;
  // byte addresses with field layouts
  localparam logic [5:0] BYTE_LED_RXTX = 6'h04;
  localparam logic [5:0] BYTE_OHCI10 = 6'h05;
  localparam logic [5:0] BYTE_PM_PHY = 6'h1c;
  localparam logic [5:0] BYTE_SHADOW = 6'h1d;
  localparam logic [5:0] BYTE_WREN = 6'h20;
  localparam logic [5:0] BYTE_LED = 6'h22;
  localparam logic [5:0] BYTE_LAT_GNT = 6'h24;
  localparam logic [5:0] BYTE_PHY_EN = 6'h26;
  localparam logic [5:0] BYTE_MINIROM = 6'h27;
  localparam logic [5:0] BYTE_SSVID = 6'h00;
  localparam logic [5:0] BYTE_SSID = 6'h02;
  localparam logic [5:0] BYTE_SSID_HI = 6'h03;
  localparam logic [5:0] BYTE_ROMHDR = 6'h28;
  localparam logic [5:0] BYTE_BUSOPT = 6'h2c;
  localparam logic [5:0] BYTE_GUID_HI = 6'h30;
  localparam logic [5:0] BYTE_GUID_LO = 6'h34;
  // field bit positions
  localparam int SELF_ID_WREN_BIT = 6;
  localparam int PM_TOP_WREN_BIT = 5;
  localparam int LED_ONE_BIT = 6;
  localparam int LED_ZERO_BIT = 5;
  localparam int LED_DUR_LSB = 3;
  // writable bits per byte
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_LED_RXTX = 8'hf0;
  localparam logic [7:0] MASK_OHCI10 = 8'h80;
  localparam logic [7:0] MASK_SHADOW = 8'hfc;
  localparam logic [7:0] MASK_WREN = 8'h63;
  localparam logic [7:0] MASK_LED = 8'h78;
  localparam logic [7:0] MASK_PHY_EN = 8'hc0;
  // register port map
  localparam logic [7:0] REG_STATUS = 8'h40;
  localparam logic [7:0] REG_CTRL = 8'h41;
  localparam int CTRL_RELOAD_BIT = 0;

  function automatic logic [7:0] rom_byte_mask(input logic [5:0] a);
    logic [7:0] m;
    m = MASK_NONE;
    if (a <= BYTE_SSID_HI) m = MASK_FULL;
    else if (a == BYTE_LED_RXTX) m = MASK_LED_RXTX;
    else if (a == BYTE_OHCI10) m = MASK_OHCI10;
    else if (a == BYTE_PM_PHY) m = MASK_FULL;
    else if (a == BYTE_SHADOW) m = MASK_SHADOW;
    else if (a == BYTE_WREN) m = MASK_WREN;
    else if (a == BYTE_LED) m = MASK_LED;
    else if (a == BYTE_LAT_GNT) m = MASK_FULL;
    else if (a == BYTE_PHY_EN) m = MASK_PHY_EN;
    else if (a >= BYTE_MINIROM && a <= IMG_LAST) m = MASK_FULL;
    return m;
  endfunction
endpackage

// >>> rom_model.sv
// serial rom model on the two-wire link, open-drain data
`timescale 1ns/1ps
module rom_model
  import rom_loader_pkg::*;
(
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_refuse,
  output logic o_sda_oe
);
  logic [7:0] mem [0:63];
  logic [7:0] sh = 8'h00;
  logic [5:0] ptr = 6'h00;
  logic d;
  int ph = 0;
  int cnt = 0;
  initial begin
    o_sda_oe = 1'b0;
    for (int k = 0; k < 64; k++) mem[k] = 8'(k * 75) ^ 8'h6d;
    mem[32] = 8'h42;
    mem[34] = 8'h30;
  end
  // start and stop only count while the clock line is high
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    ph = 1;
    cnt = 0;
  end
  always @(posedge i_sda) if (i_scl === 1'b1) ph = 0;
  always @(posedge i_scl) if (ph != 0) begin
    if (ph == 3 && cnt == 8 && i_sda) ph = 0;
    if (ph != 3 && cnt < 8) sh = {sh[6:0], i_sda};
    cnt = cnt + 1;
  end
  always @(negedge i_scl) if (ph != 0) begin
    if (cnt == 9) begin
      cnt = 0;
      if (ph == 1) ph = (sh[7:1] == ROM_DEV_ADDR && !i_refuse) ? (sh[0] ? 3 : 2) : 0;
      else if (ph == 2) ptr = sh[5:0];
      else ptr = ptr + 6'h01;
    end
    d = 1'b0;
    if (ph == 1 && cnt == 8) d = sh[7:1] == ROM_DEV_ADDR && !i_refuse;
    if (ph == 2 && cnt == 8) d = 1'b1;
    if (ph == 3 && cnt < 8) d = !mem[ptr][7 - cnt];
    o_sda_oe = d;
  end
endmodule

// >>> rom_reader.sv
// two-wire sequential reader of the serial rom, on the link clock
`timescale 1ns/1ps
module rom_reader
  import rom_loader_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_reset_n,
  input wire logic i_start_lvl,
  input wire logic i_sda_in,
  output logic o_scl_oe,
  output logic o_sda_oe,
  output logic [7:0] o_byte,
  output logic o_byte_tg,
  output logic o_done_tg,
  output logic o_nack
);
  typedef enum {S_IDLE, S_START, S_TX, S_ACKR, S_RX, S_ACKT, S_STOP} rd_state_e;
  rd_state_e st_q;
  logic start_prev_q;
  logic [9:0] div_q;
  logic [1:0] q_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [1:0] seq_q;
  logic [5:0] cnt_q;
  logic sda_s;

  sync2 #(.W(1)) u_sda_sync (
    .i_clk(i_link_clk),
    .i_reset_n(i_reset_n),
    .i_d(i_sda_in),
    .o_q(sda_s)
  );

  wire tick = (div_q == QUARTER_LAST);
  wire slot_end = tick && (q_q == 2'd3);
  wire sample = tick && (q_q == 2'd1);
  wire last_byte = (cnt_q == IMG_LAST);
  wire start_ev = i_start_lvl ^ start_prev_q;
  wire scl_hi_mid = (q_q == 2'd1) || (q_q == 2'd2);
  wire [7:0] seq_byte = (seq_q == 2'd0) ? {ROM_DEV_ADDR, 1'b0} :
                        (seq_q == 2'd1) ? ROM_WORD_ADDR : {ROM_DEV_ADDR, 1'b1};
  // open-drain line levels wanted in this quarter
  wire scl_c = (st_q == S_IDLE) ? 1'b1 : (st_q == S_STOP) ? (q_q != 2'd0) : scl_hi_mid;
  wire sda_c = (st_q == S_START) ? (q_q < 2'd2) :
               (st_q == S_STOP) ? (q_q >= 2'd2) :
               (st_q == S_TX) ? sh_q[7] :
               (st_q == S_ACKT) ? last_byte : 1'b1;

  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_scl_oe <= ~scl_c;
      o_sda_oe <= ~sda_c;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= S_IDLE;
      start_prev_q <= 1'b0;
      div_q <= '0;
      q_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      seq_q <= '0;
      cnt_q <= '0;
      o_byte <= '0;
      o_byte_tg <= 1'b0;
      o_done_tg <= 1'b0;
      o_nack <= 1'b0;
    end else begin
      start_prev_q <= i_start_lvl;
      div_q <= (tick || st_q == S_IDLE) ? 10'd0 : div_q + 10'd1;
      if (st_q == S_IDLE) q_q <= 2'd0;
      else if (tick) q_q <= q_q + 2'd1;
      case (st_q)
        S_IDLE: begin
          if (start_ev) begin
            st_q <= S_START;
            seq_q <= 2'd0;
            cnt_q <= '0;
            o_nack <= 1'b0;
          end
        end
        S_START: begin
          if (slot_end) begin
            st_q <= S_TX;
            sh_q <= seq_byte;
            bit_q <= 3'd7;
          end
        end
        S_TX: begin
          if (slot_end) begin
            if (bit_q == 3'd0) st_q <= S_ACKR;
            else begin
              bit_q <= bit_q - 3'd1;
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
        end
        S_ACKR: begin
          if (sample && sda_s) o_nack <= 1'b1;
          if (slot_end) begin
            if (o_nack) st_q <= S_STOP;
            else if (seq_q == 2'd0) begin
              seq_q <= 2'd1;
              sh_q <= ROM_WORD_ADDR;
              bit_q <= 3'd7;
              st_q <= S_TX;
            end else if (seq_q == 2'd1) begin
              seq_q <= 2'd2;
              st_q <= S_START;
            end else begin
              bit_q <= 3'd7;
              st_q <= S_RX;
            end
          end
        end
        S_RX: begin
          if (sample) sh_q <= {sh_q[6:0], sda_s};
          if (slot_end) begin
            if (bit_q == 3'd0) begin
              st_q <= S_ACKT;
              o_byte <= sh_q;
              o_byte_tg <= ~o_byte_tg;
            end else bit_q <= bit_q - 3'd1;
          end
        end
        S_ACKT: begin
          if (slot_end) begin
            cnt_q <= cnt_q + 6'd1;
            bit_q <= 3'd7;
            st_q <= last_byte ? S_STOP : S_RX;
          end
        end
        S_STOP: begin
          if (slot_end) begin
            st_q <= S_IDLE;
            o_done_tg <= ~o_done_tg;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

// >>> tb.sv
// self-checking bench for the rom configuration loader
`timescale 1ns/1ps
module tb
  import rom_loader_pkg::*;
;
  logic i_clk = 1'b0, i_link_clk = 1'b0, i_reset_n = 1'b0, i_pci_reset_n = 1'b0;
  logic i_speaker_strap_pin = 1'b1, i_slave_access = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic refuse = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic o_slave_retry, o_load_busy, o_rom_pins_active, o_self_ident_write_enable;
  logic o_user_io_pin_three_out, o_user_io_pin_three_oe, o_user_io_pin_four_out;
  logic o_user_io_pin_four_oe, o_pm_top_bit_write_enable, o_link_activity_to_led_one;
  logic o_link_activity_to_led_zero, rom_oe;
  logic [1:0] o_irq_pin_select, o_led_pulse_length_select;
  logic [15:0] o_subsys_vendor_id, o_subsys_id;
  logic [31:0] o_config_rom_header, o_bus_options, o_guid_high, o_guid_low;
  wire scl = !(o_user_io_pin_three_oe && !o_user_io_pin_three_out);
  wire i_user_io_pin_four_in = !((o_user_io_pin_four_oe && !o_user_io_pin_four_out) || rom_oe);
  int fails = 0;
  int n_checks = 0;
  always #12.5 i_clk = !i_clk;
  always #3 i_link_clk = !i_link_clk;
  rom_config_loader u_rom_config_loader (.i_clk, .i_reset_n, .i_link_clk, .i_pci_reset_n,
    .i_speaker_strap_pin, .i_slave_access, .i_user_io_pin_four_in, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_slave_retry, .o_load_busy, .o_rom_pins_active, .o_user_io_pin_three_out,
    .o_user_io_pin_three_oe, .o_user_io_pin_four_out, .o_user_io_pin_four_oe,
    .o_subsys_vendor_id, .o_subsys_id, .o_self_ident_write_enable, .o_pm_top_bit_write_enable,
    .o_irq_pin_select, .o_link_activity_to_led_one, .o_link_activity_to_led_zero,
    .o_led_pulse_length_select, .o_config_rom_header, .o_bus_options, .o_guid_high, .o_guid_low);
  rom_model u_rom_model (.i_scl(scl), .i_sda(i_user_io_pin_four_in), .i_refuse(refuse),
    .o_sda_oe(rom_oe));
  task automatic print_verdict();
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] rb(input int k);
    return u_rom_model.mem[k];
  endfunction
  // writable bits of each image byte
  function automatic logic [7:0] msk(input int a);
    case (a)
      4: return 8'hf0;
      5: return 8'h80;
      28, 36: return 8'hff;
      29: return 8'hfc;
      32: return 8'h63;
      34: return 8'h78;
      38: return 8'hc0;
      default: return (a < 4 || a > 38) ? 8'hff : 8'h00;
    endcase
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wait_busy(input logic want, input int bound);
    int n;
    n = 0;
    while (o_load_busy !== want && n < bound) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (o_load_busy !== want) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic poke(input logic exp);
    @(posedge i_clk);
    i_slave_access <= 1'b1;
    @(posedge i_clk);
    i_slave_access <= 1'b0;
    #1 chk("retry", o_slave_retry, exp);
  endtask
  task automatic power_up(input logic s);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_pci_reset_n <= 1'b0;
    i_speaker_strap_pin <= s;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_pci_reset_n <= 1'b1;
  endtask
  task automatic sc_refused();
    logic [7:0] d;
    refuse = 1'b1;
    power_up(1'b0);
    wait_busy(1'b1, 20);
    poke(1'b1);
    chk("pins", o_rom_pins_active, 1'b1);
    wait_busy(1'b0, 20000);
    rd_reg(REG_STATUS, d);
    chk("status", d, 8'h0a);
    chk("untouched", o_guid_low, 32'h0);
  endtask
  task automatic sc_load();
    logic [7:0] d;
    refuse = 1'b0;
    wr_reg(REG_CTRL, 8'h01);
    wait_busy(1'b1, 20);
    poke(1'b1);
    wait_busy(1'b0, 300000);
    poke(1'b0);
    rd_reg(REG_STATUS, d);
    chk("done", d[1:0], 2'b10);
    for (int k = 0; k < IMG_BYTES; k++) begin
      rd_reg(8'(k), d);
      chk("image", d, rb(k) & msk(k));
    end
    chk("id_low", o_guid_low, {rb(55), rb(54), rb(53), rb(52)});
    chk("id_high", o_guid_high, {rb(51), rb(50), rb(49), rb(48)});
    chk("header", o_config_rom_header, {rb(43), rb(42), rb(41), rb(40)});
    chk("options", o_bus_options, {rb(47), rb(46), rb(45), rb(44)});
    chk("subsys", {o_subsys_id, o_subsys_vendor_id}, {rb(3), rb(2), rb(1), rb(0)});
    chk("wren", {o_self_ident_write_enable, o_pm_top_bit_write_enable, o_irq_pin_select},
      4'b1010);
    chk("led", {o_link_activity_to_led_one, o_link_activity_to_led_zero,
      o_led_pulse_length_select}, 4'b0110);
    wr_reg(8'h34, 8'hff);
    rd_reg(8'h34, d);
    chk("read_only", d, rb(52));
    rd_reg(8'h80, d);
    chk("unmapped", d, 8'h00);
  endtask
  task automatic sc_skip();
    logic [7:0] d;
    power_up(1'b1);
    repeat (20) @(posedge i_clk);
    rd_reg(REG_STATUS, d);
    chk("skipped", d, 8'h04);
    chk("no_pins", {o_rom_pins_active, o_user_io_pin_three_oe, o_user_io_pin_four_oe,
      o_user_io_pin_three_out, o_user_io_pin_four_out}, 5'b0);
    chk("defaults", o_guid_low, 32'h0);
    poke(1'b0);
    // a later pci reset edge with the strap low must not start a load
    @(posedge i_clk);
    i_speaker_strap_pin <= 1'b0;
    i_pci_reset_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_pci_reset_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    #1 chk("later_edge", o_load_busy, 1'b0);
  endtask
  initial begin
    sc_refused();
    sc_load();
    sc_skip();
    print_verdict();
  end
endmodule
